// >>> rtl/essp_params.svh
// Offsets, field positions, fault codes and timing counts of the encoder status logic.
// Assumes a 250 MHz system clock.
`ifndef ESSP_PARAMS_SVH
`define ESSP_PARAMS_SVH
`define ESSP_CLK_MHZ        250
`define ESSP_MS_NS          1000000
`define ESSP_CLK_NS         4
`define ESSP_MS_CYCLES      (`ESSP_MS_NS / `ESSP_CLK_NS)
`define ESSP_ST_FAULT       15
`define ESSP_ST_HOLD        14
`define ESSP_ST_VALID       13
`define ESSP_ST_LOAD        12
`define ESSP_ST_ACK         11
`define ESSP_CW_CLEAR       15
`define ESSP_CW_HOLD        14
`define ESSP_CW_LOAD        12
`define ESSP_CW_OFFSET      11
`define ESSP_CW_RSVD_MASK   16'h07FF
`define ESSP_LC_CTRL        10
`define ESSP_LC_HB_HI       15
`define ESSP_LC_HB_LO       12
`define ESSP_STD_TRIG       31
`define ESSP_FC_POSITION    32'h0000_0001
`define ESSP_FC_BAD_CMD     32'h0000_0F01
`define ESSP_FC_HEARTBEAT   32'h0000_0F02
`define ESSP_SPD16_MAX      32'sh0000_7FFF
`define ESSP_SPD16_MIN      -32'sh0000_8000
`define ESSP_AVG_MAX        255
`define ESSP_PRESET_PARAM   65000
`endif

// >>> rtl/essp_pkg.sv
// Types shared by the encoder status, preset and speed logic.
// Assumes the cyclic words are presented already unpacked from the network.
`default_nettype none
package essp_pkg;
  typedef enum logic [1:0] {
    ESSP_RPM,
    ESSP_PER_10MS,
    ESSP_PER_100MS,
    ESSP_PER_1000MS
  } essp_unit_t;

  typedef struct packed {
    logic       profile_mode;
    logic       count_down;
    essp_unit_t speed_unit;
    logic [7:0] period_ms;
    logic [7:0] avg_depth;
    logic [31:0] steps_per_rev;
    logic [31:0] total_range;
  } essp_cfg_t;

  typedef enum {
    ESSP_ACK_IDLE,
    ESSP_ACK_BUSY,
    ESSP_ACK_DONE
  } essp_ack_t;
endpackage : essp_pkg
`default_nettype wire

// >>> rtl/essp_core.sv
// Cyclic process-data logic of an absolute encoder: status word, faults, preset, speed.
// Assumes the cyclic words arrive from network logic on sys_clk; raw_pos is synchronous too.
//
// How it works
// - Status word bits 15..11 flags, rest zero.
// - Fault sets flag, shows code, drops valid.
// - Fault codes 0001, 0F01, 0F02.
// - Clear request: busy, clear fault, restore, unbusy.
// - Valid set with position, cleared by fault/hold.
// - Hold active mirrors host hold request.
// - Load done held until trigger drops.
// - Speed unit among rpm and three periods.
// - Signed speed, sign follows direction setting.
// - Sixteen-bit speed saturates; 32-bit full.
// - Speed refreshed at each period end.
// - Period configurable 1 to 255 ms.
// - Averaging depth 1 to 255 periods.
// - Preset computes offset, kept non-volatile.
// - Range change clears preset offset.
// - Standard: bit 31 trigger, 30..0 value.
// - Only rising trigger edge acts.
// - Profile preset needs host control flag.
// - Load rising edge; offset mode shifts.
// - Profile preset value from stored parameter.
// - Clear request evaluated by level.
// - Hold zeroes outputs, clears, suppresses faults.
// - Heartbeat discontinuity raises 0F02 fault.
`include "essp_params.svh"
`default_nettype none
module essp_core
  import essp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire essp_cfg_t   cfg,
  input  wire logic [15:0] encoder_control_word,
  input  wire logic [15:0] link_control_word,
  input  wire logic [31:0] std_output_word,
  input  wire logic [31:0] preset_param,
  input  wire logic [31:0] raw_pos,
  input  wire logic        pos_fault,
  input  wire logic [31:0] nv_offset_in,
  output logic [31:0]      nv_offset_out,
  output logic             nv_write,
  output logic [15:0]      encoder_status_word,
  output logic [31:0]      position_word,
  output logic [31:0]      position_or_fault_word,
  output logic [15:0]      speed16,
  output logic [31:0]      speed32
);
  localparam int MS_CYC = `ESSP_MS_CYCLES;

  logic        fault_ff, ack_busy_ff, load_done_ff, valid_ff, loaded_ff;
  logic [31:0] fault_code_ff, offset_ff, total_range_ff;
  logic        std_trig_ff, load_trig_ff, nv_write_ff;
  logic [3:0]  hb_ff;
  essp_ack_t   ack_st_ff;
  logic [17:0] ms_cnt_ff;
  logic [7:0]  per_cnt_ff;
  logic [31:0] last_pos_ff;
  logic signed [31:0] sample_ff [0:`ESSP_AVG_MAX-1];
  logic [7:0]  wr_idx_ff, fill_ff;
  logic signed [47:0] sum_ff;
  logic signed [31:0] speed_ff;

  // Control word decode.
  wire hold_req   = encoder_control_word[`ESSP_CW_HOLD];
  wire clear_req  = encoder_control_word[`ESSP_CW_CLEAR];
  wire load_trig  = encoder_control_word[`ESSP_CW_LOAD];
  wire offs_mode  = encoder_control_word[`ESSP_CW_OFFSET];
  wire host_ctrl  = link_control_word[`ESSP_LC_CTRL];
  wire [3:0] hb   = link_control_word[`ESSP_LC_HB_HI:`ESSP_LC_HB_LO];
  wire bad_cmd    = |(encoder_control_word & `ESSP_CW_RSVD_MASK);
  wire std_trig   = std_output_word[`ESSP_STD_TRIG];

  // ===========================================================================
  // Faults
  // ===========================================================================
  wire hb_break   = (hb_ff != 4'h0) && (hb != hb_ff) && (hb != hb_ff + 4'h1)
                    && !(hb_ff == 4'hF && hb == 4'h1);
  wire new_fault  = !hold_req && !fault_ff && (pos_fault || bad_cmd || hb_break);
  wire [31:0] nxt_code = pos_fault ? `ESSP_FC_POSITION :
                         bad_cmd   ? `ESSP_FC_BAD_CMD  : `ESSP_FC_HEARTBEAT;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_ff      <= 1'b0;
      fault_code_ff <= 32'h0000_0000;
      ack_st_ff     <= ESSP_ACK_IDLE;
      ack_busy_ff   <= 1'b0;
      hb_ff         <= 4'h0;
    end else begin
      hb_ff <= hb;
      if (hold_req) begin
        fault_ff    <= 1'b0;
        ack_st_ff   <= ESSP_ACK_IDLE;
        ack_busy_ff <= 1'b0;
      end else if (new_fault) begin
        fault_ff      <= 1'b1;
        fault_code_ff <= nxt_code;
      end else begin
        case (ack_st_ff)
          ESSP_ACK_IDLE: if (fault_ff && clear_req) begin
            ack_st_ff   <= ESSP_ACK_BUSY;
            ack_busy_ff <= 1'b1;
          end
          ESSP_ACK_BUSY: begin
            fault_ff  <= 1'b0;
            ack_st_ff <= ESSP_ACK_DONE;
          end
          ESSP_ACK_DONE: begin
            ack_busy_ff <= 1'b0;
            ack_st_ff   <= ESSP_ACK_IDLE;
          end
          default: ack_st_ff <= ESSP_ACK_IDLE;
        endcase
      end
    end
  end

  // ===========================================================================
  // Preset
  // ===========================================================================
  wire std_rise  = !cfg.profile_mode && std_trig && !std_trig_ff;
  wire prof_rise = cfg.profile_mode && host_ctrl && load_trig && !load_trig_ff;
  wire [31:0] cur_pos   = raw_pos + offset_ff;
  wire [31:0] std_value = {1'b0, std_output_word[`ESSP_STD_TRIG-1:0]};
  wire [31:0] prof_tgt  = offs_mode ? cur_pos + preset_param : preset_param;
  wire [31:0] target    = cfg.profile_mode ? prof_tgt : std_value;
  wire        do_load   = std_rise || prof_rise;
  wire        range_chg = cfg.total_range != total_range_ff;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      std_trig_ff    <= 1'b0;
      load_trig_ff   <= 1'b0;
      loaded_ff      <= 1'b0;
      offset_ff      <= 32'h0000_0000;
      total_range_ff <= 32'h0000_0000;
      load_done_ff   <= 1'b0;
      nv_write_ff    <= 1'b0;
    end else begin
      std_trig_ff    <= std_trig;
      load_trig_ff   <= load_trig;
      total_range_ff <= cfg.total_range;
      loaded_ff      <= 1'b1;
      nv_write_ff    <= 1'b0;
      if (!loaded_ff) begin
        offset_ff <= nv_offset_in;
      end else if (loaded_ff && range_chg) begin
        offset_ff   <= 32'h0000_0000;
        nv_write_ff <= 1'b1;
      end else if (do_load) begin
        offset_ff   <= target - raw_pos;
        nv_write_ff <= 1'b1;
      end
      if (!load_trig) begin
        load_done_ff <= 1'b0;
      end else if (prof_rise) begin
        load_done_ff <= 1'b1;
      end
    end
  end

  // ===========================================================================
  // Speed measurement
  // ===========================================================================
  wire ms_tick  = ms_cnt_ff == 18'(MS_CYC - 1);
  wire [7:0] per_len = (cfg.period_ms == 8'h00) ? 8'h01 : cfg.period_ms;
  wire per_end  = ms_tick && (per_cnt_ff == per_len - 8'h01);
  wire [31:0] delta_raw = raw_pos - last_pos_ff;
  wire signed [31:0] delta = cfg.count_down ? -$signed(delta_raw) : $signed(delta_raw);
  wire [7:0] depth = (cfg.avg_depth == 8'h00) ? 8'h01 : cfg.avg_depth;
  wire signed [31:0] old_s = (fill_ff >= depth) ?
                             sample_ff[(wr_idx_ff >= depth) ? wr_idx_ff - depth
                                       : 8'(wr_idx_ff + 8'(`ESSP_AVG_MAX) - depth)]
                             : 32'sh0000_0000;
  wire signed [47:0] nxt_sum = sum_ff + 48'(delta) - 48'(old_s);
  wire [7:0] nxt_fill = (fill_ff >= depth) ? depth : fill_ff + 8'h01;
  wire signed [47:0] mean = nxt_sum / $signed({40'h0, nxt_fill});
  // A zero resolution would divide by zero; it is taken as one step per turn instead.
  wire [31:0] res_div = (cfg.steps_per_rev == 32'h0000_0000) ? 32'h0000_0001
                                                              : cfg.steps_per_rev;
  wire signed [63:0] per_div = $signed({56'h0, per_len});
  // Per-period mean in steps, scaled to the chosen unit by products of whole numbers.
  wire signed [63:0] scaled =
    (cfg.speed_unit == ESSP_RPM) ?
      (64'(mean) * 64'sd60000) / ($signed({32'h0, res_div}) * per_div) :
    (cfg.speed_unit == ESSP_PER_10MS)  ? (64'(mean) * 64'sd10) / per_div :
    (cfg.speed_unit == ESSP_PER_100MS) ? (64'(mean) * 64'sd100) / per_div :
                                         (64'(mean) * 64'sd1000) / per_div;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_ff   <= 18'h00000;
      per_cnt_ff  <= 8'h00;
      last_pos_ff <= 32'h0000_0000;
      wr_idx_ff   <= 8'h00;
      fill_ff     <= 8'h00;
      sum_ff      <= 48'sh0;
      speed_ff    <= 32'sh0;
    end else begin
      ms_cnt_ff <= ms_tick ? 18'h00000 : ms_cnt_ff + 18'h00001;
      if (ms_tick) begin
        per_cnt_ff <= per_end ? 8'h00 : per_cnt_ff + 8'h01;
      end
      if (per_end) begin
        last_pos_ff <= raw_pos;
        sum_ff      <= nxt_sum;
        fill_ff     <= nxt_fill;
        wr_idx_ff   <= (wr_idx_ff == 8'(`ESSP_AVG_MAX - 1)) ? 8'h00 : wr_idx_ff + 8'h01;
        speed_ff    <= 32'(scaled);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (per_end) begin
      sample_ff[wr_idx_ff] <= delta;
    end
  end

  // ===========================================================================
  // Outputs
  // ===========================================================================
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= !hold_req && !fault_ff && !new_fault && loaded_ff;
    end
  end

  // Valid drops in the same cycle as the hold flag rises, not one cycle later.
  assign encoder_status_word = {fault_ff, hold_req, valid_ff && !hold_req, load_done_ff,
                                ack_busy_ff, 11'h000};
  assign position_word          = hold_req ? 32'h0000_0000 : cur_pos;
  assign position_or_fault_word = hold_req ? 32'h0000_0000 :
                                  fault_ff ? fault_code_ff : cur_pos;
  assign speed32 = hold_req ? 32'h0000_0000 : speed_ff;
  assign speed16 = hold_req ? 16'h0000 :
                   (speed_ff > `ESSP_SPD16_MAX) ? 16'h7FFF :
                   (speed_ff < `ESSP_SPD16_MIN) ? 16'h8000 : speed_ff[15:0];
  assign nv_offset_out = offset_ff;
  assign nv_write      = nv_write_ff;

  // ===========================================================================
  // Checks
  // ===========================================================================
  property p_fault_shows_code;
    @(posedge sys_clk) disable iff (!reset_n)
      fault_ff && !hold_req |-> position_or_fault_word == fault_code_ff && !valid_ff;
  endproperty
  a_fault_shows_code: assert property (p_fault_shows_code)
    else $error("fault code not shown");

  sequence s_ack_start;
    fault_ff && clear_req && ack_st_ff == ESSP_ACK_IDLE && !hold_req && !new_fault;
  endsequence
  // A new fault in the last acknowledge cycle keeps the busy flag one cycle longer.
  sequence s_ack_run;
    !hold_req ##1 !hold_req && !new_fault;
  endsequence
  property p_ack_seq;
    @(posedge sys_clk) disable iff (!reset_n)
      s_ack_start ##1 s_ack_run |-> ##0 !fault_ff && ack_busy_ff ##1 !ack_busy_ff;
  endproperty
  a_ack_seq: assert property (p_ack_seq)
    else $error("fault acknowledge sequence wrong");

  property p_hold_zero;
    @(posedge sys_clk) disable iff (!reset_n)
      hold_req |-> encoder_status_word[`ESSP_ST_HOLD] && position_word == 32'h0
                   && speed16 == 16'h0;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("hold outputs not zero");

  property p_load_done_drop;
    @(posedge sys_clk) disable iff (!reset_n) !load_trig |=> !load_done_ff;
  endproperty
  a_load_done_drop: assert property (p_load_done_drop) else $error("load done stuck");

  property p_std_edge;
    @(posedge sys_clk) disable iff (!reset_n)
      !cfg.profile_mode && $past(std_trig) && std_trig && !range_chg && loaded_ff
      && !(cfg.profile_mode) |=> offset_ff == $past(offset_ff);
  endproperty
  a_std_edge: assert property (p_std_edge) else $error("level trigger acted");

  property p_sat16;
    @(posedge sys_clk) disable iff (!reset_n)
      !hold_req && speed_ff > `ESSP_SPD16_MAX |-> speed16 == 16'h7FFF;
  endproperty
  a_sat16: assert property (p_sat16) else $error("speed not saturated");

  property p_sat16_low;
    @(posedge sys_clk) disable iff (!reset_n)
      !hold_req && speed_ff < `ESSP_SPD16_MIN |-> speed16 == 16'h8000;
  endproperty
  a_sat16_low: assert property (p_sat16_low) else $error("low speed not saturated");

  property p_speed_steady;
    @(posedge sys_clk) disable iff (!reset_n) !per_end |=> speed_ff == $past(speed_ff);
  endproperty
  a_speed_steady: assert property (p_speed_steady) else $error("speed moved mid period");

  property p_hb_fault;
    @(posedge sys_clk) disable iff (!reset_n)
      hb_break && !hold_req && !fault_ff && !pos_fault && !bad_cmd
      |=> fault_ff && fault_code_ff == `ESSP_FC_HEARTBEAT;
  endproperty
  a_hb_fault: assert property (p_hb_fault) else $error("heartbeat fault missed");

  property p_no_ctrl;
    @(posedge sys_clk) disable iff (!reset_n)
      cfg.profile_mode && !host_ctrl && !range_chg && loaded_ff |=> offset_ff == $past(offset_ff);
  endproperty
  a_no_ctrl: assert property (p_no_ctrl) else $error("preset without host control");
endmodule : essp_core
`default_nettype wire

// >>> verif/essp_host_model.sv
// Network controller model: drives the link control word (heartbeat, host control).
// Assumes it shares sys_clk with the encoder logic.
`default_nettype none
module essp_host_model (
  input  wire logic        sys_clk,
  input  wire logic        hb_run,
  input  wire logic        hb_skip,
  input  wire logic        ctrl_on,
  output logic [15:0]      link_control_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hb_ff;
  logic [2:0] div_ff;
  // ==========================================================
  // Heartbeat
  // ==========================================================
  initial begin
    hb_ff = 4'h0;
    div_ff = 3'h0;
  end
  // A running count wraps from F to 1; a skip of three never looks like a legal step.
  always @(posedge sys_clk) begin
    div_ff <= div_ff + 3'h1;
    if (hb_run && div_ff == 3'h0) begin
      if (hb_skip) begin
        hb_ff <= hb_ff + 4'h3;
      end else if (hb_ff == 4'hF) begin
        hb_ff <= 4'h1;
      end else begin
        hb_ff <= hb_ff + 4'h1;
      end
    end
  end
  assign link_control_word = {hb_ff, 1'b0, ctrl_on, 10'h000};
endmodule : essp_host_model
`default_nettype wire

// >>> verif/test_encoder_status_preset_speed.sv
// Self-checking bench for the encoder status, fault, hold and preset logic.
// Assumes the design and the host model share sys_clk; speed periods are not reached.
`include "essp_params.svh"
`default_nettype none
module test_encoder_status_preset_speed;
  import essp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, pos_fault, hb_run, hb_skip, ctrl_on, nv_write;
  essp_cfg_t   cfg;
  logic [15:0] encoder_control_word, link_control_word, encoder_status_word, speed16;
  logic [31:0] std_output_word, preset_param, raw_pos, nv_offset_in, nv_offset_out;
  logic [31:0] position_word, position_or_fault_word, speed32, v;
  int          n_errors, n_tests;
  int unsigned m_off;
  int unsigned codes[$];

  essp_core essp_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .cfg(cfg),
    .encoder_control_word(encoder_control_word), .link_control_word(link_control_word),
    .std_output_word(std_output_word), .preset_param(preset_param), .raw_pos(raw_pos),
    .pos_fault(pos_fault), .nv_offset_in(nv_offset_in), .nv_offset_out(nv_offset_out),
    .nv_write(nv_write), .encoder_status_word(encoder_status_word),
    .position_word(position_word), .position_or_fault_word(position_or_fault_word),
    .speed16(speed16), .speed32(speed32));
  essp_host_model essp_host_model_i (.sys_clk(sys_clk), .hb_run(hb_run), .hb_skip(hb_skip),
    .ctrl_on(ctrl_on), .link_control_word(link_control_word));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // Bounded wait on one status bit; the heartbeat tick can take eight cycles.
  task automatic wait_st(input int b, input logic val);
    int k;
    k = 0;
    while (encoder_status_word[b] !== val && k < 14) begin
      cyc(1);
      k++;
    end
    check("status bit wait", encoder_status_word[b], val);
  endtask : wait_st

  task automatic chk_pos();
    check("position", position_word, raw_pos + m_off);
    check("stored offset", nv_offset_out, m_off);
  endtask : chk_pos

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Clock, watchdog, sequence
  // ==========================================================
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #(4 * 6000);
    n_errors++;
    print_verdict();
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    void'($urandom(16));
    reset_n = 1'b0;
    cfg = '{1'b0, 1'b0, ESSP_RPM, 8'h01, 8'h01, 32'h0000_1000, 32'h0100_0000};
    encoder_control_word = 16'h0000;
    std_output_word = 32'h0000_0000;
    preset_param = 32'h0000_0000;
    raw_pos = $urandom;
    pos_fault = 1'b0;
    nv_offset_in = $urandom;
    hb_run = 1'b0;
    hb_skip = 1'b0;
    ctrl_on = 1'b0;
    codes = '{`ESSP_FC_POSITION, `ESSP_FC_BAD_CMD, `ESSP_FC_HEARTBEAT};
    cyc(3);
    reset_n = 1'b1;
    hb_run = 1'b1;
    cyc(3);
    m_off = nv_offset_in;
    chk_pos();
    check("status", encoder_status_word, 16'h2000);
    check("speed", speed32, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      pos_fault = (i == 0);
      encoder_control_word = (i == 1) ? 16'h0001 << $urandom_range(10, 0) : 16'h0000;
      hb_skip = (i == 2);
      wait_st(`ESSP_ST_FAULT, 1'b1);
      hb_skip = 1'b0;
      pos_fault = 1'b0;
      encoder_control_word = 16'h8000;
      check("fault word", position_or_fault_word, codes[i]);
      check("valid", encoder_status_word[`ESSP_ST_VALID], 1'b0);
      wait_st(`ESSP_ST_ACK, 1'b1);
      check("fault in ack", encoder_status_word[`ESSP_ST_FAULT], 1'b1);
      cyc(1);
      check("fault cleared", encoder_status_word[`ESSP_ST_FAULT], 1'b0);
      cyc(1);
      check("ack end", encoder_status_word[`ESSP_ST_ACK], 1'b0);
      encoder_control_word = 16'h0000;
      wait_st(`ESSP_ST_VALID, 1'b1);
      check("restored", position_or_fault_word, raw_pos + m_off);
    end
    // A standing fault must be wiped by the hold and stay suppressed while its cause lasts; the cause is removed before the hold ends.
    pos_fault = 1'b1;
    cyc(2);
    check("fault before hold", encoder_status_word[`ESSP_ST_FAULT], 1'b1);
    encoder_control_word = 16'h4000 | (16'h0001 << $urandom_range(10, 0));
    cyc(1);
    check("hold at once", encoder_status_word, 16'h4000);
    cyc(2);
    check("hold status", encoder_status_word, 16'h4000);
    check("hold pos", position_word | position_or_fault_word, 32'h0000_0000);
    check("hold speed", {speed16, speed32[15:0]} | speed32, 32'h0000_0000);
    encoder_control_word = 16'h4000;
    pos_fault = 1'b0;
    cyc(1);
    encoder_control_word = 16'h0000;
    wait_st(`ESSP_ST_VALID, 1'b1);
    check("no fault after hold", encoder_status_word[`ESSP_ST_FAULT], 1'b0);
    v = $urandom & 32'h7FFF_FFFF;
    std_output_word = {1'b1, v[30:0]};
    cyc(1);
    check("store pulse", nv_write, 1'b1);
    cyc(1);
    check("store pulse end", nv_write, 1'b0);
    m_off = v - raw_pos;
    chk_pos();
    std_output_word = {1'b1, ~v[30:0]};
    cyc(3);
    chk_pos();
    check("no store on level", nv_write, 1'b0);
    std_output_word = 32'h0000_0000;
    raw_pos = raw_pos + 32'h0000_0005;
    cyc(1);
    chk_pos();
    cfg.profile_mode = 1'b1;
    for (int j = 0; j < 3; j++) begin
      preset_param = (j == 2) ? 32'hFFFF_FFFF : $urandom;
      ctrl_on = (j != 0);
      encoder_control_word = (j == 2) ? 16'h0800 : 16'h0000;
      cyc(2);
      encoder_control_word = encoder_control_word | 16'h1000;
      cyc(2);
      if (j == 1) begin
        m_off = preset_param - raw_pos;
      end else if (j == 2) begin
        m_off = m_off + preset_param;
      end
      chk_pos();
      cyc(3);
      check("load done", encoder_status_word[`ESSP_ST_LOAD], j != 0);
      encoder_control_word = 16'h0000;
      cyc(2);
      check("load done off", encoder_status_word[`ESSP_ST_LOAD], 1'b0);
    end
    cfg.total_range = cfg.total_range + 32'h0000_0001;
    cyc(1);
    check("range store", nv_write, 1'b1);
    cyc(1);
    m_off = 0;
    chk_pos();
    print_verdict();
  end
endmodule : test_encoder_status_preset_speed
`default_nettype wire
